// ### hw/dap_port.sv
// Purpose: Parallel output port of a dual 14-bit converter with APB control.
// Assumes: sample_clk_in runs free at twice the converter sample rate.
// Notes:   Link side on sample_clk_in, register side on clock_in.
`timescale 1ns/1ps
`include "dap_regs.svh"

//
// Summary of operation
// R1: Channel B word is 14 bits, bit0 LSB.
// R2: Channel A word is 14 bits, bit0 LSB.
// R3: Channel B over-range flag high beyond full scale.
// R4: Channel A over-range flag, independent of B.
// R5: Strobe rising edge marks new word present.
// R6: Back end may latch on strobe rise.
// R7: Format pin low two's complement, high Gray.
// R8: Words appear eight sample periods after sampling.
// R9: All outputs update together, one strobe rise each.
module dap_port
  import dap_pkg::*;
(
  // Register-side clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  reset_in,
  // APB slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [11:0]           paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // Link clock, format pin and quantizer results
  input  wire logic                  sample_clk_in,
  input  wire logic                  format_select_in,
  input  wire logic [`DAP_RAW_W-1:0] chan_a_raw_in,
  input  wire logic [`DAP_RAW_W-1:0] chan_b_raw_in,
  // Parallel output port
  output logic [`DAP_WORD_W-1:0]     chan_a_out,
  output logic [`DAP_WORD_W-1:0]     chan_b_out,
  output logic                       chan_a_over_range_out,
  output logic                       chan_b_over_range_out,
  output logic                       output_word_valid_strobe_out
);

  // ======================================================================
  // Full-scale limits of the output word, taken from its width.
  localparam logic signed [`DAP_RAW_W-1:0] FS_MAX =
    `DAP_RAW_W'((1 << (`DAP_WORD_W - 1)) - 1);
  localparam logic signed [`DAP_RAW_W-1:0] FS_MIN =
    `DAP_RAW_W'(-(1 << (`DAP_WORD_W - 1)));

  // Converts a raw result to a clipped two's-complement word and flag.
  function automatic dap_word_t clip_word(input logic [`DAP_RAW_W-1:0] raw);
    dap_word_t w;
    logic signed [`DAP_RAW_W-1:0] s;
    s = signed'(raw);
    w.over_range = 1'b0;
    w.code       = s[`DAP_WORD_W-1:0];
    if (s > FS_MAX)
    begin
      w.over_range = 1'b1;
      w.code       = FS_MAX[`DAP_WORD_W-1:0];
    end
    else if (s < FS_MIN)
    begin
      w.over_range = 1'b1;
      w.code       = FS_MIN[`DAP_WORD_W-1:0];
    end
    return w;
  endfunction : clip_word

  // Recodes a two's-complement word to Gray code via offset binary.
  function automatic dap_code_t to_gray(input dap_code_t tc);
    dap_code_t ob;
    ob = tc ^ {1'b1, {(`DAP_WORD_W - 1){1'b0}}};
    return ob ^ (ob >> 1);
  endfunction : to_gray

  // ======================================================================
  // Register-side state
  logic [31:0]      ctrl_r;
  logic [1:0]       sticky_r;
  logic [1:0]       sticky_nxt;
  logic [15:0]      count_r;
  logic [31:0]      rdata_nxt;
  logic             err_nxt;
  logic             setup;
  logic             wr_access;
  logic [3:0]       st_meta_r;
  logic [3:0]       st_sync_r;
  logic [2:0]       tgl_sync_r;

  // Link-side state
  logic [1:0]       lrst_r;
  logic             lrst;
  logic [2:0]       lctrl_meta_r;
  logic [2:0]       lctrl_r;
  logic [1:0]       fmt_r;
  logic             gray_mode;
  logic             link_en;
  dap_div_t         div_mode;
  logic [2:0]       phase_r;
  logic [2:0]       last_phase;
  logic [2:0]       half_phase;
  logic             tick;
  logic             upd_tgl_r;
  dap_pair_t        pipe_in;
  dap_pair_t        pipe_out;

  // ======================================================================
  // APB decode
  // ======================================================================

  // The slave answers in the first access cycle, so pready rises from setup.
  assign setup     = psel_in & ~penable_in;
  assign wr_access = psel_in & penable_in & pwrite_in & pready_out;

  // Read data and error are formed during setup and registered for access.
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    err_nxt   = 1'b0;
    unique case (paddr_in)
      `DAP_CTRL_OFS:   rdata_nxt = ctrl_r;
      `DAP_STATUS_OFS: rdata_nxt = {28'h000_0000, st_sync_r};
      `DAP_STICKY_OFS: rdata_nxt = {30'h0000_0000, sticky_r};
      `DAP_COUNT_OFS:  rdata_nxt = {16'h0000, count_r};
      default:         err_nxt   = 1'b1;
    endcase
  end

  // Answer registers; all bus outputs come straight from flip-flops.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end
    else
    begin
      pready_out  <= setup;
      pslverr_out <= setup & err_nxt;
      prdata_out  <= (setup & ~pwrite_in) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // ======================================================================
  // Control register
  // ======================================================================

  // Only enable and divider bits are stored; the rest read as zero.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      ctrl_r <= `DAP_CTRL_RST;
    else if (wr_access && paddr_in == `DAP_CTRL_OFS)
    begin
      ctrl_r <= 32'h0000_0000;
      ctrl_r[`DAP_CTRL_EN_BIT] <= pwdata_in[`DAP_CTRL_EN_BIT];
      ctrl_r[`DAP_CTRL_DIV_MSB:`DAP_CTRL_DIV_LSB] <=
        pwdata_in[`DAP_CTRL_DIV_MSB:`DAP_CTRL_DIV_LSB];
    end
  end

  // ======================================================================
  // Status crossing from the link side
  // ======================================================================

  // Flags, format and enable are slow levels, so two flops suffice.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      st_meta_r <= 4'h0;
      st_sync_r <= 4'h0;
    end
    else
    begin
      st_meta_r <= {link_en, gray_mode, chan_b_over_range_out, chan_a_over_range_out};
      st_sync_r <= st_meta_r;
    end
  end

  // Sticky flags clear on a one written, but a new flag wins over the clear.
  always_comb
  begin
    sticky_nxt = sticky_r;
    if (wr_access && paddr_in == `DAP_STICKY_OFS)
      sticky_nxt = sticky_r & ~pwdata_in[1:0];
    sticky_nxt = sticky_nxt | st_sync_r[`DAP_ST_ORB_BIT:`DAP_ST_ORA_BIT]; // R3 R4
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      sticky_r <= 2'b00;
    else
      sticky_r <= sticky_nxt;
  end

  // Each output update toggles a bit; its synced edges count updates.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      tgl_sync_r <= 3'b000;
    else
      tgl_sync_r <= {tgl_sync_r[1:0], upd_tgl_r};
  end

  // Update counter wraps silently; a write of any value clears it.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      count_r <= 16'h0000;
    else if (wr_access && paddr_in == `DAP_COUNT_OFS)
      count_r <= 16'h0000;
    else if (tgl_sync_r[2] ^ tgl_sync_r[1])
      count_r <= count_r + 16'h0001;
  end

  // ======================================================================
  // Link-side reset and control crossing
  // ======================================================================

  // Reset is carried into the sampling domain by a two-flop synchroniser.
  always_ff @(posedge sample_clk_in)
  begin
    lrst_r <= {lrst_r[0], reset_in};
  end

  assign lrst = lrst_r[1];

  // Enable and divider cross as levels; change the divider only while
  // disabled, since its two bits may land on different edges.
  always_ff @(posedge sample_clk_in)
  begin
    if (lrst)
    begin
      lctrl_meta_r <= 3'b000;
      lctrl_r      <= 3'b000;
    end
    else
    begin
      lctrl_meta_r <= ctrl_r[`DAP_CTRL_DIV_MSB:`DAP_CTRL_EN_BIT];
      lctrl_r      <= lctrl_meta_r;
    end
  end

  // The format pin is static but asynchronous, so it is synchronised too.
  always_ff @(posedge sample_clk_in)
  begin
    if (lrst)
      fmt_r <= 2'b00;
    else
      fmt_r <= {fmt_r[0], format_select_in};
  end

  assign gray_mode = fmt_r[1];
  assign link_en   = lctrl_r[0];
  assign div_mode  = dap_div_t'(lctrl_r[2:1]);

  // ======================================================================
  // Output sample period
  // ======================================================================

  // Two link clocks per sample; divide modes stretch the period.
  always_comb
  begin
    unique case (div_mode)
      DAP_DIV1: last_phase = 3'd1;
      DAP_DIV2: last_phase = 3'd3;
      DAP_DIV4: last_phase = 3'd7;
      default:  last_phase = 3'd1;
    endcase
    half_phase = last_phase >> 1;
  end

  assign tick = link_en & (phase_r == last_phase);

  always_ff @(posedge sample_clk_in)
  begin
    if (lrst || !link_en || tick)
      phase_r <= 3'd0;
    else
      phase_r <= phase_r + 3'd1;
  end

  // ======================================================================
  // Pipeline
  // ======================================================================

  // Range check and clip happen as each sample enters the delay line.
  assign pipe_in.chan_a = clip_word(chan_a_raw_in); // R4
  assign pipe_in.chan_b = clip_word(chan_b_raw_in); // R3

  // A sample enters stage 0 on its own tick; eight stages then put it on the pins eight ticks later.
  dap_pipe #(
    .DEPTH (`DAP_LATENCY)
  ) u_pipe (
    .clock_in   (sample_clk_in),
    .reset_in   (lrst),
    .advance_in (tick),
    .data_in    (pipe_in),
    .data_out   (pipe_out)
  ); // R8

  // ======================================================================
  // Output stage
  // ======================================================================

  // Both words and flags change together on the tick, strobe low.
  always_ff @(posedge sample_clk_in)
  begin
    if (lrst)
    begin
      chan_a_out            <= '0;
      chan_b_out            <= '0;
      chan_a_over_range_out <= 1'b0;
      chan_b_over_range_out <= 1'b0;
    end
    else if (tick) // R9
    begin
      chan_a_out <= gray_mode ? to_gray(pipe_out.chan_a.code)
                              : pipe_out.chan_a.code; // R2 R7
      chan_b_out <= gray_mode ? to_gray(pipe_out.chan_b.code)
                              : pipe_out.chan_b.code; // R1 R7
      chan_a_over_range_out <= pipe_out.chan_a.over_range; // R4
      chan_b_over_range_out <= pipe_out.chan_b.over_range; // R3
    end
  end

  // Strobe falls with the data change and rises half a period later,
  // giving the back end setup margin before it latches on the rise.
  always_ff @(posedge sample_clk_in)
  begin
    if (lrst || !link_en)
      output_word_valid_strobe_out <= 1'b0;
    else if (tick)
      output_word_valid_strobe_out <= 1'b0; // R5
    else if (phase_r == half_phase)
      output_word_valid_strobe_out <= 1'b1; // R5 R6 R9
  end

  // Toggle per update for the register-side counter.
  always_ff @(posedge sample_clk_in)
  begin
    if (lrst)
      upd_tgl_r <= 1'b0;
    else if (tick)
      upd_tgl_r <= ~upd_tgl_r;
  end

endmodule : dap_port

// ### pkg/dap_regs.svh
// Purpose: Register offsets, field positions, reset values and counts of the output port.
// Assumes: Byte addresses on a 32-bit APB bus, one aligned word per register.
// Notes:   Definitions only; included by the package and by each design file.
`ifndef DAP_REGS_SVH
`define DAP_REGS_SVH

// ======================================================================
// Register offsets
`define DAP_CTRL_OFS     12'h000
`define DAP_STATUS_OFS   12'h004
`define DAP_STICKY_OFS   12'h008
`define DAP_COUNT_OFS    12'h00C

// ======================================================================
// Field positions
`define DAP_CTRL_EN_BIT  0
`define DAP_CTRL_DIV_LSB 1
`define DAP_CTRL_DIV_MSB 2
`define DAP_ST_ORA_BIT   0
`define DAP_ST_ORB_BIT   1
`define DAP_ST_GRAY_BIT  2
`define DAP_ST_EN_BIT    3

// ======================================================================
// Reset values, widths and counts
`define DAP_CTRL_RST     32'h0000_0001
`define DAP_WORD_W       14
`define DAP_RAW_W        16
`define DAP_LATENCY      8

`endif

// ### pkg/dap_pkg.sv
// Purpose: Types shared by the output port and its pipeline.
// Assumes: dap_regs.svh supplies the widths.
// Notes:   Holds types only; numbers live in the header.
`include "dap_regs.svh"

package dap_pkg;

  // ======================================================================
  // Output word types
  typedef logic [`DAP_WORD_W-1:0] dap_code_t;

  typedef struct packed {
    logic      over_range;
    dap_code_t code;
  } dap_word_t;

  typedef struct packed {
    dap_word_t chan_a;
    dap_word_t chan_b;
  } dap_pair_t;

  // ======================================================================
  // Output sample period selection
  typedef enum logic [1:0] {
    DAP_DIV1 = 2'b00,
    DAP_DIV2 = 2'b01,
    DAP_DIV4 = 2'b10
  } dap_div_t;

endpackage : dap_pkg

// ### hw/dap_pipe.sv
// Purpose: Fixed-depth delay line for the paired channel words.
// Assumes: advance_in pulses once per output sample period.
// Notes:   Runs on the sampling clock; depth sets the latency in samples.
`timescale 1ns/1ps
`include "dap_regs.svh"

module dap_pipe
  import dap_pkg::*;
#(
  parameter int DEPTH = `DAP_LATENCY
)
(
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // Stream
  input  wire logic advance_in,
  input  dap_pair_t data_in,
  output dap_pair_t data_out
);

  dap_pair_t stage_r [DEPTH];

  // ======================================================================
  // Each stage moves one step per sample tick and holds otherwise.
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_stage
    always_ff @(posedge clock_in)
    begin
      if (reset_in)
        stage_r[g] <= '0;
      else if (advance_in)
        stage_r[g] <= (g == 0) ? data_in : stage_r[(g == 0) ? 0 : g - 1];
    end
  end

  assign data_out = stage_r[DEPTH-1];

endmodule : dap_pipe

// ### sim/dap_backend.sv
// Purpose: Back-end capture logic that sits beside the output port.
// Assumes: Words and flags are settled before the strobe rises.
// Notes:   Counts every strobe rise so the bench can see missing or extra updates.
`timescale 1ns/1ps

module dap_backend
  import dap_pkg::*;
(
  // Port pins
  input  wire logic strobe_in,
  input  dap_pair_t pins_in,
  // Captured result
  output dap_pair_t cap_out,
  output int        count_out
);
  // ==========
  // Capture
  // Latch on the rising edge only; a level latch would see the next update land.
  initial count_out = 0;
  always @(posedge strobe_in)
  begin
    cap_out   <= pins_in;
    count_out <= count_out + 1;
  end
endmodule : dap_backend

// ### sim/dap_port_chk.sv
// Purpose: Concurrent checks on the output port pins and its APB slave.
// Assumes: Bound to dap_port; reset_in also guards the link side.
// Notes:   Link checks run on sample_clk_in, APB checks on clock_in.
`timescale 1ns/1ps
`include "dap_regs.svh"

module dap_port_chk
  import dap_pkg::*;
(
  // Register side
  input wire logic                  clock_in,
  input wire logic                  reset_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic [11:0]           paddr_in,
  input wire logic [31:0]           prdata_out,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  // Link side
  input wire logic                  sample_clk_in,
  input wire logic [`DAP_WORD_W-1:0] chan_a_out,
  input wire logic [`DAP_WORD_W-1:0] chan_b_out,
  input wire logic                  chan_a_over_range_out,
  input wire logic                  chan_b_over_range_out,
  input wire logic                  output_word_valid_strobe_out
);
  // ==========
  // Saturated codes are the only legal words while a flag is up, in either coding.
  function automatic logic sat_code(input logic [13:0] c);
    return c == 14'h1FFF || c == 14'h2000 || c == 14'h0000;
  endfunction : sat_code

  sequence s_update;
    $changed({chan_a_out, chan_b_out, chan_a_over_range_out, chan_b_over_range_out});
  endsequence

  sequence s_strobe_rise;
    !output_word_valid_strobe_out ##1 output_word_valid_strobe_out;
  endsequence

  // ==========
  // Link side: updates land with the strobe low, and the strobe rises on settled pins.
  a_update_strobe_low: assert property (@(posedge sample_clk_in) disable iff (reset_in)
    s_update |-> !output_word_valid_strobe_out) else $error("pins changed with strobe high");
  a_rise_stable: assert property (@(posedge sample_clk_in) disable iff (reset_in)
    s_strobe_rise |-> $stable({chan_a_out, chan_b_out, chan_a_over_range_out,
    chan_b_over_range_out})) else $error("pins changed at strobe rise");
  a_flag_a_sat: assert property (@(posedge sample_clk_in) disable iff (reset_in)
    chan_a_over_range_out |-> sat_code(chan_a_out)) else $error("flag A on unsaturated word");
  a_flag_b_sat: assert property (@(posedge sample_clk_in) disable iff (reset_in)
    chan_b_over_range_out |-> sat_code(chan_b_out)) else $error("flag B on unsaturated word");

  // ==========
  // APB side: zero-wait answer, one cycle wide, error on unmapped places above 12'h00C.
  a_ready_setup: assert property (@(posedge clock_in) disable iff (reset_in)
    psel_in && !penable_in |=> pready_out ##1 !pready_out) else $error("pready not one cycle");
  a_ready_cause: assert property (@(posedge clock_in) disable iff (reset_in)
    pready_out |-> $past(psel_in && !penable_in)) else $error("pready without setup");
  a_err_ready: assert property (@(posedge clock_in) disable iff (reset_in)
    pslverr_out |-> pready_out) else $error("pslverr without pready");
  a_unmapped_err: assert property (@(posedge clock_in) disable iff (reset_in)
    psel_in && !penable_in && paddr_in > 12'h00C |=> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  a_rdata_idle: assert property (@(posedge clock_in) disable iff (reset_in)
    !pready_out |-> prdata_out == 32'h0) else $error("read data outside access");
endmodule : dap_port_chk

bind dap_port dap_port_chk u_chk (.clock_in(clock_in), .reset_in(reset_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .sample_clk_in(sample_clk_in),
  .chan_a_out(chan_a_out), .chan_b_out(chan_b_out),
  .chan_a_over_range_out(chan_a_over_range_out), .chan_b_over_range_out(chan_b_over_range_out),
  .output_word_valid_strobe_out(output_word_valid_strobe_out));

// ### sim/test_dap_port.sv
// Purpose: Self-checking bench for the dual converter output port.
// Assumes: Zero-wait APB slave; raw words change only at strobe rises.
// Notes:   A word set at rise m is expected in the capture taken at rise m+9.
`timescale 1ns/1ps
`include "dap_regs.svh"

module test_dap_port
  import dap_pkg::*;
;
  logic        clock_in;
  logic        sample_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        format;
  logic [15:0] raw_a;
  logic [15:0] raw_b;
  logic [13:0] word_a;
  logic [13:0] word_b;
  logic        ovr_a;
  logic        ovr_b;
  logic        strobe;
  dap_pair_t   cap;
  int          ncap;
  int          miscompares = 0;
  int          num_checks = 0;
  logic [31:0] rd;
  logic        er;

  // ==========
  // Clocks: the link clock starts off phase so the domains never line up.
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  initial
  begin
    sample_clk = 1'b0;
    #1.3;
    forever #7.5 sample_clk = ~sample_clk;
  end

  dap_port uut (.clock_in(clock_in), .reset_in(reset), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .sample_clk_in(sample_clk),
    .format_select_in(format), .chan_a_raw_in(raw_a), .chan_b_raw_in(raw_b),
    .chan_a_out(word_a), .chan_b_out(word_b), .chan_a_over_range_out(ovr_a),
    .chan_b_over_range_out(ovr_b), .output_word_valid_strobe_out(strobe));
  dap_backend u_be (.strobe_in(strobe), .pins_in({ovr_a, word_a, ovr_b, word_b}),
    .cap_out(cap), .count_out(ncap));

  // ==========
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Saturate, then optionally Gray-code via offset binary; flag in bit 14.
  function automatic logic [14:0] enc(input int r, input logic g);
    logic [13:0] b;
    b = (r > 8191) ? 14'h1FFF : (r < -8192) ? 14'h2000 : r[13:0];
    if (g)
      b = (b ^ 14'h2000) ^ ((b ^ 14'h2000) >> 1);
    return {(r > 8191 || r < -8192), b};
  endfunction : enc

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do
      @(posedge clock_in);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ==========
  // Scenarios
  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, `DAP_CTRL_RST, "ctrl reset");
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h1, "unmapped write");
    apb(1'b0, 12'h010, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
    $display("t_regs done");
  endtask : t_regs

  task automatic t_div();
    int d;
    int c0;
    realtime t0;
    for (d = 2; d >= 0; d--)
    begin
      apb(1'b1, 12'h000, 32'h0);
      repeat (4) @(posedge sample_clk);
      c0 = ncap;
      repeat (20) @(posedge sample_clk);
      chk(32'(ncap - c0), 32'h0, "disabled");
      apb(1'b1, 12'h000, 32'(d * 2 + 1));
      repeat (2) @(posedge strobe);
      t0 = $realtime;
      @(posedge strobe);
      chk(32'(int'(($realtime - t0) / 15.0)), 32'(2 << d), "period");
    end
    $display("t_div done");
  endtask : t_div

  task automatic t_latency();
    int m;
    for (m = 1; m <= 14; m++)
    begin
      @(posedge strobe);
      raw_a <= 16'(m);
      raw_b <= 16'(-m);
      #1;
      if (m > 9)
        chk(32'(cap), 32'({enc(m - 9, 1'b0), enc(9 - m, 1'b0)}), "latency");
    end
    $display("t_latency done");
  endtask : t_latency

  task automatic t_range(input logic g);
    int va[6] = '{8191, 8192, -8192, -8193, 32767, -32768};
    int i;
    @(posedge sample_clk);
    format <= g;
    for (i = 0; i < 6; i++)
    begin
      @(posedge strobe);
      raw_a <= 16'(va[i]);
      raw_b <= 16'(va[5 - i]);
      repeat (9) @(posedge strobe);
      #1;
      chk(32'(cap), 32'({enc(va[i], g), enc(va[5 - i], g)}), "range");
    end
    $display("t_range done");
  endtask : t_range

  // Runs after the Gray pass: A sits at negative over-range, B in range.
  task automatic t_status();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0000_000D, "status");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0000_0003, "sticky");
    apb(1'b1, 12'h008, 32'h0000_0003);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0000_0001, "sticky set wins");
    apb(1'b1, 12'h00C, 32'h0);
    repeat (10) @(posedge strobe);
    apb(1'b0, 12'h00C, 32'h0);
    // The crossing may shift one update either way of the ten strobe rises.
    chk(32'(rd >= 32'd9 && rd <= 32'd11), 32'h1, "update count");
    $display("t_status done");
  endtask : t_status

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // ==========
  // Watchdog: the tests need about 6 us, so 100 us means a hang.
  initial
  begin
    #100000;
    miscompares++;
    conclude();
  end

  // ==========
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, format, reset} = 5'b00001;
    paddr = 12'h000;
    pwdata = 32'h0;
    raw_a = 16'h0;
    raw_b = 16'h0;
    repeat (12) @(posedge clock_in);
    reset <= 1'b0;
    repeat (4) @(posedge sample_clk);
    t_regs();
    t_div();
    t_latency();
    t_range(1'b0);
    t_range(1'b1);
    t_status();
    conclude();
  end
endmodule : test_dap_port
